/* nalu_core.sv */
/*
  Nibble accumulator datapath: logic operations, increment, rotations, port
  input and output, and the indirect program memory address.
  Assumes the sequencer presents one decoded operation per cycle with a strobe,
  and that register, program word and port inputs are stable on the same clock.
  The reset request output is expected to reach the device reset logic outside.
*/
`timescale 1ns/1ps
`default_nettype none

module nalu_core (
  // Clock and reset.
  input  wire logic                                 core_clk,
  input  wire logic                                 srst,
  // Decoded operation from the sequencer.
  input  wire logic                                 op_valid,
  input  wire nalu_pkg::nalu_op_e                   op_code,
  input  wire nalu_pkg::nalu_src_e                  op_src,
  // Operand sources.
  input  wire logic [nalu_pkg::NIB_W-1:0]           reg_nibble,
  input  wire logic [nalu_pkg::WORD_W-1:0]          rom_word,
  input  wire logic [nalu_pkg::NIB_W-1:0]           imm_nibble,
  // Indirect address sources.
  input  wire logic [nalu_pkg::PAGE_W-1:0]          rom_page_select,
  input  wire logic [nalu_pkg::NIB_W-1:0]           pair_high_nibble,
  input  wire logic [nalu_pkg::NIB_W-1:0]           pair_low_nibble,
  // Port selection and pins.
  input  wire logic                                 port_group,
  input  wire logic [nalu_pkg::PORT_IDX_W-1:0]      port_idx,
  input  wire logic [2*nalu_pkg::PORT_NUM*nalu_pkg::NIB_W-1:0] port_pins_in,
  // Results.
  output logic      [nalu_pkg::NIB_W-1:0]           acc,
  output logic                                      carry_flag,
  output logic                                      device_reset_req,
  output logic      [nalu_pkg::ADDR_W-1:0]          rom_addr,
  output logic      [2*nalu_pkg::PORT_NUM*nalu_pkg::NIB_W-1:0] port_out
);

  localparam int NW = nalu_pkg::NIB_W;
  localparam int PW = 2*nalu_pkg::PORT_NUM*NW;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Port pins are asynchronous; two stages before the accumulator sees them.
  // Reads therefore see a pin change two edges late, which the sequencer allows for.
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= port_pins_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Operand selection
  // ------------------------------------------------------------
  // Only the program word bits 7..0 are ever tapped; 9 and 8 are dropped.
  // The immediate source also serves the OR immediate form, whose carry is cleared.
  wire [NW-1:0] rom_hi = rom_word[nalu_pkg::ROM_HI_MSB:nalu_pkg::ROM_HI_LSB];
  wire [NW-1:0] rom_lo = rom_word[nalu_pkg::ROM_LO_MSB:nalu_pkg::ROM_LO_LSB];

  wire [NW-1:0] operand = (op_src == nalu_pkg::NALU_SRC_REG)    ? reg_nibble :
                          (op_src == nalu_pkg::NALU_SRC_ROM_HI) ? rom_hi :
                          (op_src == nalu_pkg::NALU_SRC_ROM_LO) ? rom_lo :
                                                                  imm_nibble;

  // Selecting one nibble from the flat port vector, used for both groups.
  function automatic logic [NW-1:0] pick_port(input logic [PW-1:0] vec,
                                              input logic          grp,
                                              input logic [nalu_pkg::PORT_IDX_W-1:0] idx);
    int sel;
    sel = int'(grp) * nalu_pkg::PORT_NUM + int'(idx);
    if (idx >= nalu_pkg::PORT_IDX_W'(nalu_pkg::PORT_NUM))
      pick_port = nalu_pkg::NIB_ZERO;
    else
      pick_port = vec[sel*NW +: NW];
  endfunction

  wire [NW-1:0] port_value = pick_port(pin_s2_r, port_group, port_idx);

  // ------------------------------------------------------------
  // Datapath state
  // ------------------------------------------------------------
  // Declared ahead of the result wires that read them.
  // The reset request register holds for one cycle only, so a single zero
  // rotate cannot lock the datapath in reset.
  logic [NW-1:0] acc_r;
  logic [NW-1:0] acc_nxt;
  logic          carry_r;
  logic          carry_nxt;
  logic          rst_req_r;
  logic          rst_req_nxt;

  // ------------------------------------------------------------
  // Arithmetic and logic results
  // ------------------------------------------------------------
  // Carry for AND and XOR is the AND of the two sign bits, per source.
  // Increment carry comes from the truncated sum, so fifteen plus one sets it.
  wire          a3       = acc_r[nalu_pkg::MSB];
  wire          and_cy   = a3 & operand[nalu_pkg::MSB];
  wire [NW-1:0] inc_val  = NW'(acc_r + nalu_pkg::NIB_ONE);
  wire [NW-1:0] rot_val  = {acc_r[NW-2:0], a3};
  wire          acc_zero = (acc_r == nalu_pkg::NIB_ZERO);

  // ------------------------------------------------------------
  // Next-state decode
  // ------------------------------------------------------------
  always_comb
  begin
    acc_nxt     = acc_r;
    carry_nxt   = carry_r;
    rst_req_nxt = 1'b0;
    if (op_valid)
    begin
      case (op_code)
        nalu_pkg::NALU_OP_AND:
        begin
          acc_nxt   = acc_r & operand;
          carry_nxt = and_cy;
        end
        nalu_pkg::NALU_OP_OR:
        begin
          acc_nxt   = acc_r | operand;
          carry_nxt = 1'b0;
        end
        nalu_pkg::NALU_OP_XOR:
        begin
          acc_nxt   = acc_r ^ operand;
          carry_nxt = and_cy;
        end
        nalu_pkg::NALU_OP_INC:
        begin
          acc_nxt   = inc_val;
          carry_nxt = (inc_val == nalu_pkg::NIB_ZERO);
        end
        nalu_pkg::NALU_OP_ROT:
        begin
          acc_nxt   = rot_val;
          carry_nxt = a3;
        end
        nalu_pkg::NALU_OP_ROTZ:
        begin
          // A zero accumulator raises the reset request instead of rotating.
          // Accumulator and carry hold here; the request clears both one edge later.
          if (acc_zero)
            rst_req_nxt = 1'b1;
          else
          begin
            acc_nxt   = rot_val;
            carry_nxt = a3;
          end
        end
        nalu_pkg::NALU_OP_PIN:
          acc_nxt = port_value;
        // No-op and port output leave the accumulator and carry alone.
        default:
        begin
          acc_nxt   = acc_r;
          carry_nxt = carry_r;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  // The reset request also clears the datapath so a pulse leaves known state.
  // The trade is that any op issued in the request cycle is lost; the
  // sequencer is being reset at that point anyway.
  always_ff @(posedge core_clk)
  begin
    if (srst || rst_req_r)
    begin
      acc_r     <= nalu_pkg::ACC_RST;
      carry_r   <= nalu_pkg::CARRY_RST;
      rst_req_r <= 1'b0;
    end
    else
    begin
      acc_r     <= acc_nxt;
      carry_r   <= carry_nxt;
      rst_req_r <= rst_req_nxt;
    end
  end

  assign acc              = acc_r;
  assign carry_flag       = carry_r;
  assign device_reset_req = rst_req_r;

  // Indirect address is combinational from registered sources upstream.
  // Page bits sit on top, the register zero pair below them.
  assign rom_addr = {rom_page_select, pair_high_nibble, pair_low_nibble};

  // ------------------------------------------------------------
  // Port output latches
  // ------------------------------------------------------------
  // An op met in the reset-request cycle is discarded, port writes included,
  // so the latches agree with the accumulator that the sequencer sees.
  // The latch takes the accumulator as it stands before this edge's update.
  wire pout_wr = op_valid && !rst_req_r && (op_code == nalu_pkg::NALU_OP_POUT);

  nalu_port_latch u_latch (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (pout_wr),
    .wr_group (port_group),
    .wr_idx   (port_idx),
    .wr_data  (acc_r),
    .port_out (port_out)
  );

endmodule

`default_nettype wire

/* nalu_core_properties.sv */
/* Assertions on the accumulator unit ports.
   Assumes one clock and srst synchronous, active high. */
`timescale 1ns/1ps
`default_nettype none
module nalu_core_properties (
  // Clock, reset and operation.
  input wire logic                core_clk,
  input wire logic                srst,
  input wire logic                op_valid,
  input wire nalu_pkg::nalu_op_e  op_code,
  input wire nalu_pkg::nalu_src_e op_src,
  // Operands and address parts.
  input wire logic [3:0]          reg_nibble,
  input wire logic [9:0]          rom_word,
  input wire logic [3:0]          imm_nibble,
  input wire logic [1:0]          rom_page_select,
  input wire logic [3:0]          pair_high_nibble,
  input wire logic [3:0]          pair_low_nibble,
  // Results.
  input wire logic [3:0]          acc,
  input wire logic                carry_flag,
  input wire logic                device_reset_req,
  input wire logic [9:0]          rom_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // An op met in the reset-request cycle is dropped, so it never counts as taken.
  wire logic       go = op_valid && !device_reset_req;
  wire logic [3:0] opnd = (op_src == nalu_pkg::NALU_SRC_REG) ? reg_nibble :
    (op_src == nalu_pkg::NALU_SRC_ROM_HI) ? rom_word[7:4] :
    (op_src == nalu_pkg::NALU_SRC_ROM_LO) ? rom_word[3:0] : imm_nibble;
  wire logic       rotz0 = go && op_code == nalu_pkg::NALU_OP_ROTZ && acc == 4'h0;
  and_result_a:
    assert property (go && op_code == nalu_pkg::NALU_OP_AND |=> acc == $past(acc & opnd)
      && carry_flag == $past(acc[3] & opnd[3])) else $error("and result wrong");
  or_result_a:
    assert property (go && op_code == nalu_pkg::NALU_OP_OR |=> acc == $past(acc | opnd)
      && !carry_flag) else $error("or result wrong");
  xor_result_a:
    assert property (go && op_code == nalu_pkg::NALU_OP_XOR |=> acc == $past(acc ^ opnd)
      && carry_flag == $past(acc[3] & opnd[3])) else $error("xor result wrong");
  inc_wrap_a:
    assert property (go && op_code == nalu_pkg::NALU_OP_INC |=> acc == 4'($past(acc) + 4'h1)
      && carry_flag == (acc == 4'h0)) else $error("increment result wrong");
  rotate_left_a:
    assert property (go && (op_code == nalu_pkg::NALU_OP_ROT || (op_code == nalu_pkg::NALU_OP_ROTZ && acc != 4'h0))
      |=> acc == $past({acc[2:0], acc[3]}) && carry_flag == $past(acc[3])) else $error("rotate result wrong");
  zero_reset_a:
    assert property (rotz0 |=> device_reset_req ##1 (!device_reset_req && acc == 4'h0 && !carry_flag))
      else $error("zero rotate did not reset");
  no_stray_reset_a:
    assert property (!rotz0 |=> !device_reset_req) else $error("reset request without cause");
  rom_address_a:
    assert property (rom_addr == {rom_page_select, pair_high_nibble, pair_low_nibble})
      else $error("indirect address wrong");
  cover property (go && op_code == nalu_pkg::NALU_OP_INC && acc == 4'hf);
  cover property (rotz0);
  cover property (go && op_code == nalu_pkg::NALU_OP_XOR && op_src == nalu_pkg::NALU_SRC_ROM_HI);
endmodule
bind nalu_core nalu_core_properties chk (.core_clk, .srst, .op_valid, .op_code, .op_src, .reg_nibble,
  .rom_word, .imm_nibble, .rom_page_select, .pair_high_nibble, .pair_low_nibble, .acc, .carry_flag,
  .device_reset_req, .rom_addr);
`default_nettype wire

/* nalu_pkg.sv */
/*
  Package for the nibble accumulator logic unit: operation codes, field widths,
  reset values and port index constants shared by the datapath and its port latches.
  Assumes the instruction sequencer decodes instruction words into these codes.
*/

package nalu_pkg;

  localparam int NIB_W      = 4;
  localparam int WORD_W     = 10;
  localparam int PAGE_W     = 2;
  localparam int PAIR_W     = 8;
  localparam int ADDR_W     = PAGE_W + PAIR_W;
  localparam int PORT_IDX_W = 3;
  localparam int PORT_NUM   = 5;
  localparam int MSB        = 3;
  localparam int ROM_HI_MSB = 7;
  localparam int ROM_HI_LSB = 4;
  localparam int ROM_LO_MSB = 3;
  localparam int ROM_LO_LSB = 0;

  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic       CARRY_RST = 1'b0;
  localparam logic [3:0] PORT_RST  = 4'h0;
  localparam logic [3:0] NIB_ONE   = 4'h1;
  localparam logic [3:0] NIB_ZERO  = 4'h0;

  typedef enum logic [3:0] {
    NALU_OP_NOP,
    NALU_OP_AND,
    NALU_OP_OR,
    NALU_OP_XOR,
    NALU_OP_INC,
    NALU_OP_ROT,
    NALU_OP_ROTZ,
    NALU_OP_PIN,
    NALU_OP_POUT
  } nalu_op_e;

  typedef enum logic [1:0] {
    NALU_SRC_REG,
    NALU_SRC_ROM_HI,
    NALU_SRC_ROM_LO,
    NALU_SRC_IMM
  } nalu_src_e;

endpackage

/* nalu_port_latch.sv */
/*
  Output latches for the two port nibble groups, one nibble per valid index.
  Assumes writes come from the datapath on the same clock; unused indexes ignore writes.
*/
`timescale 1ns/1ps
`default_nettype none

module nalu_port_latch (
  // Clock and reset.
  input  wire logic                                core_clk,
  input  wire logic                                srst,
  // Write request.
  input  wire logic                                wr_en,
  input  wire logic                                wr_group,
  input  wire logic [nalu_pkg::PORT_IDX_W-1:0]     wr_idx,
  input  wire logic [nalu_pkg::NIB_W-1:0]          wr_data,
  // Latched port values, group 0 then group 1.
  output logic      [2*nalu_pkg::PORT_NUM*nalu_pkg::NIB_W-1:0] port_out
);

  // ------------------------------------------------------------
  // Latch array
  // ------------------------------------------------------------
  // Index 2 has no pin, so its slot never loads and stays at reset.
  genvar g;
  generate
    for (g = 0; g < 2*nalu_pkg::PORT_NUM; g++)
    begin : g_lat
      logic [nalu_pkg::NIB_W-1:0] lat_r;
      wire                        hit = wr_en && (wr_group == (g / nalu_pkg::PORT_NUM))
                                        && (int'(wr_idx) == (g % nalu_pkg::PORT_NUM))
                                        && ((g % nalu_pkg::PORT_NUM) != 2);
      always_ff @(posedge core_clk)
      begin
        if (srst)
          lat_r <= nalu_pkg::PORT_RST;
        else if (hit)
          lat_r <= wr_data;
      end
      assign port_out[g*nalu_pkg::NIB_W +: nalu_pkg::NIB_W] = lat_r;
    end
  endgenerate

endmodule

`default_nettype wire

/* nalu_rom_model.sv */
/* Program memory seen by the datapath.
   Assumes an asynchronous read of the addressed word. */
`timescale 1ns/1ps
`default_nettype none
module nalu_rom_model (
  // Address in, word out.
  input  wire logic [9:0] rom_addr,
  output logic      [9:0] rom_word
);
  // Each address holds its own pattern, with the two top bits varying as well.
  assign rom_word = {rom_addr[0] ^ rom_addr[9], rom_addr[9:1]} ^ 10'h3a5;
endmodule
`default_nettype wire

/* nibble_accumulator_logic_unit_test.sv */
/* Random self-checking bench for the accumulator unit.
   Assumes the program memory model and the property checker. */
`timescale 1ns/1ps
`default_nettype none
module nibble_accumulator_logic_unit_test;
  logic core_clk = 1'b0, srst = 1'b1, op_valid = 1'b0, port_group = 1'b0, mcy, mreq;
  nalu_pkg::nalu_op_e op_code = nalu_pkg::NALU_OP_NOP;
  nalu_pkg::nalu_src_e op_src = nalu_pkg::NALU_SRC_REG;
  logic [3:0] reg_nibble = 4'h0, imm_nibble = 4'h0, pair_high_nibble = 4'h0, pair_low_nibble = 4'h0, acc, macc;
  logic [1:0] rom_page_select = 2'h0;
  logic [2:0] port_idx = 3'h0;
  logic [39:0] port_pins_in = 40'h0, port_out, pv;
  logic [9:0] rom_word, rom_addr;
  logic carry_flag, device_reset_req;
  logic [3:0] mport [10];
  logic [31:0] s = 32'h32f1f387;
  int fail_count = 0, checked = 0, ph;
  always #12.5 core_clk = ~core_clk;
  nalu_rom_model rom (.rom_addr(rom_addr), .rom_word(rom_word));
  nalu_core DUT (.core_clk, .srst, .op_valid, .op_code, .op_src, .reg_nibble, .rom_word, .imm_nibble,
    .rom_page_select, .pair_high_nibble, .pair_low_nibble, .port_group, .port_idx, .port_pins_in,
    .acc, .carry_flag, .device_reset_req, .rom_addr, .port_out);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reference step for the op presented at this edge, written from the instruction set.
  task automatic model();
    logic [9:0] a, w;
    logic [3:0] o;
    int k;
    a = {rom_page_select, pair_high_nibble, pair_low_nibble};
    w = {a[0] ^ a[9], a[9:1]} ^ 10'h3a5;
    o = op_src == nalu_pkg::NALU_SRC_REG ? reg_nibble : op_src == nalu_pkg::NALU_SRC_ROM_HI ? w[7:4] :
      op_src == nalu_pkg::NALU_SRC_ROM_LO ? w[3:0] : imm_nibble;
    k = port_group * 5 + port_idx;
    if (srst || mreq)
    begin
      macc = 4'h0;
      mcy = 1'b0;
      mreq = 1'b0;
      if (srst)
        mport = '{default: 4'h0};
    end
    else if (op_valid)
      case (op_code)
        nalu_pkg::NALU_OP_AND: {mcy, macc} = {macc[3] & o[3], macc & o};
        nalu_pkg::NALU_OP_OR: {mcy, macc} = {1'b0, macc | o};
        nalu_pkg::NALU_OP_XOR: {mcy, macc} = {macc[3] & o[3], macc ^ o};
        nalu_pkg::NALU_OP_INC: {mcy, macc} = {macc == 4'hf, 4'(macc + 4'h1)};
        nalu_pkg::NALU_OP_ROT, nalu_pkg::NALU_OP_ROTZ:
          if (op_code == nalu_pkg::NALU_OP_ROTZ && macc == 4'h0)
            mreq = 1'b1;
          else
            {mcy, macc} = {macc[3], macc[2:0], macc[3]};
        nalu_pkg::NALU_OP_PIN: macc = port_idx > 3'h4 ? 4'h0 : port_pins_in[4*k +: 4];
        nalu_pkg::NALU_OP_POUT: if (port_idx != 3'h2 && port_idx < 3'h5) mport[k] = macc;
        default: ;
      endcase
  endtask
  // ----------------------------------------
  // Main sequence, with a second reset halfway; pins move only under reset so the synchroniser settles.
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge core_clk);
      model();
      s = xs(s);
      ph = i % 1500;
      srst <= ph < 1;
      op_valid <= ph > 4 && s[1:0] != 2'h0;
      op_code <= nalu_pkg::nalu_op_e'(4'(s[7:2] % 9));
      op_src <= nalu_pkg::nalu_src_e'(s[9:8]);
      {reg_nibble, imm_nibble, pair_high_nibble, pair_low_nibble} <= s[25:10];
      {rom_page_select, port_group, port_idx} <= s[31:26];
      if (ph == 0)
        port_pins_in <= {s, s[7:0] ^ 8'h5a};
      #1;
      for (int j = 0; j < 10; j++)
        pv[4*j +: 4] = mport[j];
      check("acc", 40'(macc), 40'(acc));
      check("carry_flag", 40'(mcy), 40'(carry_flag));
      check("device_reset_req", 40'(mreq), 40'(device_reset_req));
      check("port_out", pv, port_out);
    end
    close_out();
  end
endmodule
`default_nettype wire
